// ---- core/cspw_pkg.sv ----
// Constants and carrier types for the clock select and power warning block.
// Assumes one reference clock domain; crystal and supply status arrive as pins.
package cspw_pkg;

   localparam int unsigned WARMUP_CYCLES          = 65536;
   localparam int unsigned WARMUP_W               = 17;
   localparam int unsigned IRQ_FLAG_PWR_BIT       = 0;
   localparam int unsigned EXT_CLOCK_SELECT_BIT   = 4;
   localparam logic        EXT_CLOCK_SELECT_RESET = 1'h0;
   localparam logic        LOW_POWER_MODE_RESET   = 1'h0;
   localparam logic        FLAG_RESET             = 1'h0;
   localparam logic        MASK_RESET             = 1'h0;

   typedef enum logic [1:0]
   {
      CSPW_SRC_RC    = 2'h0,
      CSPW_SRC_XTAL  = 2'h1,
      CSPW_SRC_EXT   = 2'h2
   } cspw_src_t;

   typedef enum logic [1:0]
   {
      CSPW_ST_WARM   = 2'h0,
      CSPW_ST_RUN    = 2'h1,
      CSPW_ST_STOP   = 2'h2
   } cspw_state_t;

   // Host-written configuration bits.
   typedef struct packed
   {
      logic external_clock_select;
      logic low_power_clock_mode;
      logic power_fail_irq_mask;
   } cspw_cfg_t;

   // Status reported back to the host.
   typedef struct packed
   {
      cspw_src_t source;
      logic      warm_done;
      logic      crystal_enable;
      logic      power_fail_flag;
   } cspw_stat_t;

endpackage

// ---- core/cspw_top.sv ----
// Clock source selection, crystal warm-up counting and power-fail warning.
// Assumes crystal_in edges and the supply comparator are asynchronous pins.
// Assumes reset_i and por_reset_i are synchronous to ref_clk_i.
// Operation
// R1 - Set warning flag on low supply outside stop
// R2 - Flag sticky until host clear or reset
// R3 - Flag and mask drive active-low interrupt
// R4 - One selected system clock for everything
// R5 - Reset selects the high-frequency clock
// R6 - Count 65,536 crystal cycles, RC meanwhile
// R7 - Crystal off in stop, rewarm on exit
// R8 - External clock bit disables crystal oscillator
// R9 - External clock bit cleared only by power-on (code also clears it on a host configuration write of zero)
// R10 - RC clock during warm-up or low-power mode
// R11 - Grounded crystal input never finishes warm-up
// R12 - Host rewrites configuration after every reset
// R13 - Status readable without pausing processing
// R14 - Initialization entry clears low-power mode bit
// R15 - Host writes zero to clear warning flag
`timescale 1ns/100ps
`default_nettype none
module cspw_top #(
   parameter int unsigned WARMUP_COUNT = cspw_pkg::WARMUP_CYCLES
)(
   input  wire logic                ref_clk_i,
   input  wire logic                reset_i,
   input  wire logic                por_reset_i,
   input  wire logic                clk_en_i,
   input  wire logic                crystal_in_i,
   input  wire logic                supply_below_warn_i,
   input  wire logic                stop_req_i,
   input  wire logic                stop_exit_i,
   input  wire logic                init_entry_i,
   input  wire logic                cfg_we_i,
   input  wire cspw_pkg::cspw_cfg_t cfg_i,
   input  wire logic                flag_clear_i,
   output var  cspw_pkg::cspw_stat_t stat_o,
   output logic                     irq_n_o,
   output logic                     crystal_out_o
);

   logic                  xin_s1;
   logic                  xin_s2;
   logic                  xin_s3;
   logic                  sup_s1;
   logic                  sup_s2;
   logic                  ext_sel;
   logic                  low_power_clock_mode;
   logic                  mask;
   logic                  flag;
   logic [cspw_pkg::WARMUP_W-1:0] warm_cnt;
   cspw_pkg::cspw_state_t state;
   logic                  next_ext_sel;
   logic                  next_low_power_clock_mode;
   logic                  next_mask;
   logic                  next_flag;
   logic [cspw_pkg::WARMUP_W-1:0] next_warm_cnt;
   cspw_pkg::cspw_state_t next_state;
   cspw_pkg::cspw_stat_t  next_stat;
   logic                  next_irq_n;
   logic                  next_xtal_out;
   logic                  xin_rise;

   // Count value at which the last warm-up edge arrives.
   localparam logic [cspw_pkg::WARMUP_W-1:0] WARM_LAST = cspw_pkg::WARMUP_W'(WARMUP_COUNT - 1);

   // Pins pass two flops before use; the third flop only feeds edge detection.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i || por_reset_i)
      begin
         xin_s1 <= 1'h0;
         xin_s2 <= 1'h0;
         xin_s3 <= 1'h0;
         sup_s1 <= 1'h0;
         sup_s2 <= 1'h0;
      end
      else if (clk_en_i)
      begin
         xin_s1 <= crystal_in_i;
         xin_s2 <= xin_s1;
         xin_s3 <= xin_s2;
         sup_s1 <= supply_below_warn_i;
         sup_s2 <= sup_s1;
      end
   end

   // A rising crystal edge is seen in the same cycle that it leaves the synchroniser.
   assign xin_rise = xin_s2 & ~xin_s3;

   // Next values of configuration, warning flag and warm-up sequencing.
   always_comb
   begin
      next_ext_sel  = ext_sel;
      next_low_power_clock_mode = low_power_clock_mode;
      next_mask     = mask;
      next_flag     = flag;
      next_state    = state;
      next_warm_cnt = warm_cnt;
      if (cfg_we_i)
      begin
         next_ext_sel = cfg_i.external_clock_select; // R8
         next_low_power_clock_mode = cfg_i.low_power_clock_mode;
         next_mask    = cfg_i.power_fail_irq_mask;
      end
      // Entering initialization always clears low-power mode; the crystal or external clock follows once warm-up has ended.
      if (init_entry_i)
      begin
         next_low_power_clock_mode = cspw_pkg::LOW_POWER_MODE_RESET; // R14
      end
      if (flag_clear_i)
      begin
         next_flag = 1'h0; // R15
      end
      // The set comes after the clear so that a low supply wins a same-cycle clear.
      if (sup_s2 && state != cspw_pkg::CSPW_ST_STOP)
      begin
         next_flag = 1'h1; // R1 R2
      end
      // Crystal edges only advance the count while warming up.
      unique case (state)
         cspw_pkg::CSPW_ST_WARM:
         begin
            if (stop_req_i)
            begin
               next_state    = cspw_pkg::CSPW_ST_STOP;
               next_warm_cnt = '0;
            end
            else if (xin_rise) // R11
            begin
               if (warm_cnt == WARM_LAST)
               begin
                  next_state = cspw_pkg::CSPW_ST_RUN; // R6
               end
               next_warm_cnt = warm_cnt + cspw_pkg::WARMUP_W'(1);
            end
         end
         cspw_pkg::CSPW_ST_RUN:
         begin
            if (stop_req_i)
            begin
               next_state = cspw_pkg::CSPW_ST_STOP;
            end
         end
         // The oscillator is off here; leaving restarts the warm-up from zero.
         cspw_pkg::CSPW_ST_STOP:
         begin
            if (stop_exit_i)
            begin
               next_state    = cspw_pkg::CSPW_ST_WARM; // R7
               next_warm_cnt = '0;
            end
         end
         // The unused state code falls back to warm-up.
         default:
         begin
            next_state = cspw_pkg::CSPW_ST_WARM;
         end
      endcase
   end

   // Outputs are built from next values so that each one leaves a register.
   always_comb
   begin
      next_irq_n    = ~(next_flag & next_mask); // R3
      next_xtal_out = (next_state != cspw_pkg::CSPW_ST_STOP) && !next_ext_sel; // R7 R8
      next_stat.power_fail_flag = next_flag; // R13
      next_stat.crystal_enable  = next_xtal_out;
      next_stat.warm_done       = (next_state == cspw_pkg::CSPW_ST_RUN);
      if (next_state != cspw_pkg::CSPW_ST_RUN || next_low_power_clock_mode)
      begin
         next_stat.source = cspw_pkg::CSPW_SRC_RC; // R10 R4
      end
      else if (next_ext_sel)
      begin
         next_stat.source = cspw_pkg::CSPW_SRC_EXT;
      end
      else
      begin
         next_stat.source = cspw_pkg::CSPW_SRC_XTAL;
      end
   end

   // The external clock bit survives ordinary resets; only power-on or a host write of zero clears it.
   always_ff @(posedge ref_clk_i)
   begin
      if (por_reset_i)
      begin
         ext_sel <= cspw_pkg::EXT_CLOCK_SELECT_RESET; // R9
      end
      else if (clk_en_i && !reset_i)
      begin
         ext_sel <= next_ext_sel;
      end
   end

   // Both resets clear everything here; the external clock bit lives apart.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i || por_reset_i)
      begin
         low_power_clock_mode <= cspw_pkg::LOW_POWER_MODE_RESET; // R5
         mask          <= cspw_pkg::MASK_RESET;
         flag          <= cspw_pkg::FLAG_RESET;
         state         <= cspw_pkg::CSPW_ST_WARM;
         warm_cnt      <= '0;
         stat_o        <= '0;
         irq_n_o       <= 1'h1;
         crystal_out_o <= 1'h0;
      end
      else if (clk_en_i)
      begin
         low_power_clock_mode <= next_low_power_clock_mode;
         mask          <= next_mask;
         flag          <= next_flag;
         state         <= next_state;
         warm_cnt      <= next_warm_cnt;
         stat_o        <= next_stat;
         irq_n_o       <= next_irq_n;
         crystal_out_o <= next_xtal_out;
      end
   end

endmodule
`default_nettype wire

// ---- sim/cspw_checker.sv ----
// Assertion checker for cspw_top, bound to every instance.
// Assumes it sees only the top module's ports.
`timescale 1ns/100ps
`default_nettype none
module cspw_checker (
   input wire logic                 ref_clk_i,
   input wire logic                 reset_i,
   input wire logic                 por_reset_i,
   input wire logic                 clk_en_i,
   input wire logic                 crystal_in_i,
   input wire logic                 supply_below_warn_i,
   input wire logic                 stop_req_i,
   input wire logic                 flag_clear_i,
   input wire cspw_pkg::cspw_stat_t stat_o,
   input wire logic                 irq_n_o,
   input wire logic                 crystal_out_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i || por_reset_i);
   property p_set; (supply_below_warn_i && clk_en_i)[*4] ##0 crystal_out_o
      |=> stat_o.power_fail_flag; endproperty
   a_set: assert property (p_set) else $error("flag not set");
   property p_hold; stat_o.power_fail_flag && !flag_clear_i |=> stat_o.power_fail_flag;
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_irq; !irq_n_o |-> stat_o.power_fail_flag; endproperty
   a_irq: assert property (p_irq) else $error("irq without flag");
   property p_clr; (!supply_below_warn_i && clk_en_i)[*3] ##0 flag_clear_i
      |=> !stat_o.power_fail_flag; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_stop; stop_req_i && clk_en_i
      |=> !crystal_out_o && stat_o.source == cspw_pkg::CSPW_SRC_RC; endproperty
   a_stop: assert property (p_stop) else $error("stop kept crystal");
   property p_rc; !stat_o.warm_done |-> stat_o.source == cspw_pkg::CSPW_SRC_RC; endproperty
   a_rc: assert property (p_rc) else $error("source before warm");
   property p_gnd; $stable(crystal_in_i)[*6] |-> !$rose(stat_o.warm_done); endproperty
   a_gnd: assert property (p_gnd) else $error("warm without edges");
   property p_ext; stat_o.source == cspw_pkg::CSPW_SRC_EXT |-> !crystal_out_o; endproperty
   a_ext: assert property (p_ext) else $error("crystal on in ext");
endmodule
bind cspw_top cspw_checker u_chk (.*);
`default_nettype wire

// ---- sim/cspw_xtal.sv ----
// Crystal pin model: toggles while running, held at ground otherwise.
// Assumes the reference clock is much faster than this crystal.
`timescale 1ns/100ps
`default_nettype none
module cspw_xtal (
   input  wire logic run_i,
   output var  logic crystal_o
);
   initial crystal_o = 1'h0;
   always #130 crystal_o = run_i ? ~crystal_o : 1'h0;
endmodule
`default_nettype wire

// ---- sim/cspw_top_test.sv ----
// Self-checking bench for cspw_top with a short warm-up count.
// Assumes the crystal model on crystal_in_i and a 20 MHz reference.
`timescale 1ns/100ps
`default_nettype none
module cspw_top_test;
   logic                 clk = 1'h0;
   logic                 rst = 1'h1;
   logic                 por = 1'h1;
   logic                 en  = 1'h1;
   logic                 run = 1'h0;
   logic                 sup = 1'h0;
   logic                 stp = 1'h0;
   logic                 ext = 1'h0;
   logic                 ini = 1'h0;
   logic                 we  = 1'h0;
   logic                 clr = 1'h0;
   logic [2:0]           cfg = 3'h0;
   cspw_pkg::cspw_stat_t st;
   logic                 irq;
   logic                 xo;
   logic                 xi;
   int                   err_count = 0;
   int                   tests_run = 0;

   cspw_top #(.WARMUP_COUNT(4)) dut (
      .ref_clk_i           (clk),
      .reset_i             (rst),
      .por_reset_i         (por),
      .clk_en_i            (en),
      .crystal_in_i        (xi),
      .supply_below_warn_i (sup),
      .stop_req_i          (stp),
      .stop_exit_i         (ext),
      .init_entry_i        (ini),
      .cfg_we_i            (we),
      .cfg_i               (cfg),
      .flag_clear_i        (clr),
      .stat_o              (st),
      .irq_n_o             (irq),
      .crystal_out_o       (xo)
   );

   cspw_xtal xm (
      .run_i     (run),
      .crystal_o (xi)
   );

   initial forever #25 clk = ~clk;

   task automatic t(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask

   task automatic wcfg(input logic [2:0] v);
      cfg = v;
      we  = 1'h1;
      t(1);
      we  = 1'h0;
   endtask

   task automatic rr(input logic p);
      rst = 1'h1;
      por = p;
      t(4);
      rst = 1'h0;
      por = 1'h0;
   endtask

   // Waits a bounded time for the warm-up to end; a timeout ends the run.
   task automatic ww;
      int i;
      for (i = 0; i < 300 && st.warm_done !== 1'h1; i++)
      begin
         t(1);
      end
      chk("warm", {7'h00, st.warm_done}, 8'h01);
      if (i == 300)
      begin
         end_sim;
      end
   endtask

   initial
   begin
      t(4);
      rst = 1'h0;
      por = 1'h0;
      chk("reset", {st, irq, xo}, 8'h02);
      t(40);
      chk("ground", {2'h0, st}, 8'h02);
      run = 1'h1;
      ww;
      chk("xtal", {6'h00, st.source}, {6'h00, cspw_pkg::CSPW_SRC_XTAL});
      wcfg(3'h1);
      sup = 1'h1;
      t(4);
      chk("flag", {6'h00, st.power_fail_flag, irq}, 8'h02);
      sup = 1'h0;
      t(4);
      chk("sticky", {7'h00, st.power_fail_flag}, 8'h01);
      clr = 1'h1;
      t(1);
      clr = 1'h0;
      chk("clear", {6'h00, st.power_fail_flag, irq}, 8'h01);
      stp = 1'h1;
      t(1);
      stp = 1'h0;
      chk("stop", {5'h00, xo, st.source}, 8'h00);
      sup = 1'h1;
      t(4);
      chk("stop supply", {7'h00, st.power_fail_flag}, 8'h00);
      sup = 1'h0;
      t(3);
      ext = 1'h1;
      t(1);
      ext = 1'h0;
      chk("rewarm", {6'h00, st.warm_done, xo}, 8'h01);
      ww;
      wcfg(3'h3);
      t(1);
      chk("low_power_clock_mode", {6'h00, st.source}, {6'h00, cspw_pkg::CSPW_SRC_RC});
      ini = 1'h1;
      t(1);
      ini = 1'h0;
      chk("init", {6'h00, st.source}, {6'h00, cspw_pkg::CSPW_SRC_XTAL});
      en  = 1'h0;
      sup = 1'h1;
      t(6);
      chk("frozen", {7'h00, st.power_fail_flag}, 8'h00);
      en  = 1'h1;
      t(4);
      chk("thawed", {6'h00, st.power_fail_flag, irq}, 8'h02);
      sup = 1'h0;
      wcfg(3'h4);
      rr(1'h0);
      chk("reset flag", {7'h00, st.power_fail_flag}, 8'h00);
      ww;
      chk("ext", {5'h00, xo, st.source}, {5'h00, 1'h0, cspw_pkg::CSPW_SRC_EXT});
      rr(1'h1);
      ww;
      chk("por", {6'h00, st.source}, {6'h00, cspw_pkg::CSPW_SRC_XTAL});
      end_sim;
   end
endmodule
`default_nettype wire
